//--- rtl/cfa_dev.sv
// Design decisions made here: the sampled strobe edges and the row mastership held from master reset.
`include "cfa_defines.svh"
`default_nettype none

module cfa_dev #(
  parameter int WORD_W = `CFA_WORD_W,
  parameter int DEPTH  = `CFA_STACK_DEPTH
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // link to neighbours and gating
  cfa_if.dev        link,
  // local status
  output logic      is_master_out,
  output logic      holds_output_out
);
  localparam int BW = $clog2(WORD_W);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_W - 1);

  logic              clr;
  logic              sin_clk_q;
  logic              sout_clk_q;
  logic              top_q;
  logic              sin_rise;
  logic              sout_rise;
  logic              top_rise;
  logic              is_master_r;
  logic [WORD_W-1:0] in_reg_r;
  logic [BW-1:0]     in_cnt_r;
  logic              in_full_r;
  logic              in_pushed_r;
  logic              ser_take;
  logic              push;
  logic              in_clear;
  logic [WORD_W-1:0] out_reg_r;
  logic [BW-1:0]     out_cnt_r;
  logic              out_valid_r;
  logic              load_out;
  logic              ser_shift;
  logic [WORD_W-1:0] stk_dout;
  logic              stk_full;
  logic              stk_empty;
  logic              irf_n_r;
  logic              ore_n_r;
  logic [WORD_W-1:0] par_out_r;
  logic              par_oe_r;
  logic              sdo_r;
  logic              sdo_oe_r;

  assign clr = !rst_n_in || !link.master_reset_n;

  // strobe edges, all sampled on clk_in
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sin_clk_q  <= 1'b0;
      sout_clk_q <= 1'b0;
      top_q      <= 1'b1;
    end
    else
    begin
      sin_clk_q  <= link.serial_in_clock;
      sout_clk_q <= link.serial_out_clock;
      top_q      <= link.parallel_extract_n;
    end
  end

  assign sin_rise  = link.serial_in_clock && !sin_clk_q;
  assign sout_rise = link.serial_out_clock && !sout_clk_q;
  assign top_rise  = link.parallel_extract_n && !top_q;

  // row mastership held from the last reset cycle
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      is_master_r <= 1'b0;
    end
    else if (!link.master_reset_n)
    begin
      is_master_r <= !link.serial_input_enable_n;
    end
  end

  // input section
  assign ser_take = sin_rise && !link.serial_input_enable_n && !in_full_r
                    && !link.parallel_load;
  assign push     = !link.transfer_to_stack_n && in_full_r && !in_pushed_r
                    && !link.parallel_load && !stk_full;
  assign in_clear = in_pushed_r && (is_master_r || link.serial_input_enable_n);

  always_ff @(posedge clk_in)
  begin
    if (clr)
    begin
      in_reg_r    <= '0;
      in_cnt_r    <= '0;
      in_full_r   <= 1'b0;
      in_pushed_r <= 1'b0;
    end
    else if (link.parallel_load)
    begin
      in_reg_r    <= link.par_data_in;
      in_cnt_r    <= '0;
      in_full_r   <= 1'b1;
      in_pushed_r <= 1'b0;
    end
    else
    begin
      if (ser_take)
      begin
        in_reg_r[in_cnt_r] <= link.serial_data_in;
        in_cnt_r           <= in_cnt_r + 1'b1;
        if (in_cnt_r == LAST_BIT)
        begin
          in_full_r <= 1'b1;
        end
      end
      if (push)
      begin
        in_pushed_r <= 1'b1;
      end
      else if (in_clear)
      begin
        in_full_r   <= 1'b0;
        in_pushed_r <= 1'b0;
        in_cnt_r    <= '0;
      end
    end
  end

  // stack between input and output registers
  cfa_stack #(
    .WORD_W (WORD_W),
    .DEPTH  (DEPTH)
  ) u_stack (
    .clk_in    (clk_in),
    .clear_in  (clr),
    .push_in   (push),
    .data_in   (in_reg_r),
    .pop_in    (load_out),
    .data_out  (stk_dout),
    .full_out  (stk_full),
    .empty_out (stk_empty)
  );

  // output section; reload blocked while extract held low
  assign load_out  = !out_valid_r && !stk_empty && !link.serial_extract_request_n
                     && link.parallel_extract_n && top_q;
  assign ser_shift = sout_rise && !link.serial_output_enable_n && out_valid_r;

  always_ff @(posedge clk_in)
  begin
    if (clr)
    begin
      out_reg_r   <= '0;
      out_cnt_r   <= '0;
      out_valid_r <= 1'b0;
    end
    else if (load_out)
    begin
      out_reg_r   <= stk_dout;
      out_cnt_r   <= '0;
      out_valid_r <= 1'b1;
    end
    else if (top_rise)
    begin
      out_valid_r <= 1'b0;
    end
    else if (ser_shift)
    begin
      out_reg_r <= out_reg_r >> 1;
      out_cnt_r <= out_cnt_r + 1'b1;
      if (out_cnt_r == LAST_BIT)
      begin
        out_valid_r <= 1'b0;
      end
    end
  end

  // registered status outputs
  always_ff @(posedge clk_in)
  begin
    if (clr)
    begin
      irf_n_r <= `CFA_IRF_N_RST;
      ore_n_r <= `CFA_ORE_N_RST;
    end
    else
    begin
      irf_n_r <= !in_full_r;
      ore_n_r <= out_valid_r && link.parallel_extract_n && top_q
                 && (is_master_r || link.serial_output_enable_n);
    end
  end

  // data outputs
  always_ff @(posedge clk_in)
  begin
    if (clr)
    begin
      par_out_r <= '0;
      par_oe_r  <= 1'b0;
      sdo_r     <= 1'b0;
      sdo_oe_r  <= 1'b0;
    end
    else
    begin
      par_out_r <= out_reg_r;
      par_oe_r  <= !link.output_drive_enable_n;
      sdo_r     <= out_reg_r[0];
      sdo_oe_r  <= out_valid_r && !link.serial_output_enable_n;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      is_master_out    <= 1'b0;
      holds_output_out <= 1'b0;
    end
    else
    begin
      is_master_out    <= is_master_r;
      holds_output_out <= out_valid_r;
    end
  end

  assign link.input_register_full_n   = irf_n_r;
  assign link.output_register_empty_n = ore_n_r;
  assign link.par_data_out            = par_out_r;
  assign link.par_data_oe             = par_oe_r;
  assign link.serial_data_out         = sdo_r;
  assign link.serial_data_oe          = sdo_oe_r;
endmodule : cfa_dev

`default_nettype wire

//--- rtl/cfa_defines.svh
`ifndef CFA_DEFINES_SVH
`define CFA_DEFINES_SVH

// word and storage shape of one device
`define CFA_WORD_W      4
`define CFA_STACK_DEPTH 14

// status levels while initialised
`define CFA_IRF_N_RST   1'b1
`define CFA_ORE_N_RST   1'b0

`endif

//--- rtl/cfa_pkg.sv
`default_nettype none

package cfa_pkg;

  typedef enum logic [1:0] {
    CFA_XTR_IDLE,
    CFA_XTR_LOW,
    CFA_XTR_WAIT
  } cfa_xtr_e;

endpackage : cfa_pkg

`default_nettype wire

//--- rtl/cfa_if.sv
`default_nettype none

interface cfa_if #(parameter int WORD_W = 4);
  logic              master_reset_n;
  logic              serial_input_enable_n;
  logic              serial_in_clock;
  logic              serial_data_in;
  logic              transfer_to_stack_n;
  logic              parallel_load;
  logic [WORD_W-1:0] par_data_in;
  logic              input_register_full_n;
  logic              serial_output_enable_n;
  logic              serial_out_clock;
  logic              serial_extract_request_n;
  logic              parallel_extract_n;
  logic              output_drive_enable_n;
  logic              output_register_empty_n;
  logic [WORD_W-1:0] par_data_out;
  logic              par_data_oe;
  logic              serial_data_out;
  logic              serial_data_oe;

  modport dev (
    input  master_reset_n, serial_input_enable_n, serial_in_clock, serial_data_in,
    input  transfer_to_stack_n, parallel_load, par_data_in,
    input  serial_output_enable_n, serial_out_clock, serial_extract_request_n,
    input  parallel_extract_n, output_drive_enable_n,
    output input_register_full_n, output_register_empty_n, par_data_out, par_data_oe,
    output serial_data_out, serial_data_oe
  );

  modport ext (
    output master_reset_n, serial_input_enable_n, serial_in_clock, serial_data_in,
    output transfer_to_stack_n, parallel_load, par_data_in,
    output serial_output_enable_n, serial_out_clock, serial_extract_request_n,
    output parallel_extract_n, output_drive_enable_n,
    input  input_register_full_n, output_register_empty_n, par_data_out, par_data_oe,
    input  serial_data_out, serial_data_oe
  );
endinterface : cfa_if

`default_nettype wire

//--- rtl/cfa_stack.sv
`default_nettype none

module cfa_stack #(
  parameter int WORD_W = 4,
  parameter int DEPTH  = 14
) (
  // clock and clear
  input  wire logic              clk_in,
  input  wire logic              clear_in,
  // write side
  input  wire logic              push_in,
  input  wire logic [WORD_W-1:0] data_in,
  // read side
  input  wire logic              pop_in,
  output logic      [WORD_W-1:0] data_out,
  // occupancy
  output logic                   full_out,
  output logic                   empty_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WORD_W-1:0] mem_r [DEPTH];
  logic [PW-1:0]     wr_ptr_r;
  logic [PW-1:0]     rd_ptr_r;
  logic [CW-1:0]     count_r;
  logic              do_push;
  logic              do_pop;

  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;
  assign full_out  = (count_r == FULL);
  assign empty_out = (count_r == '0);
  assign data_out  = mem_r[rd_ptr_r];

  always_ff @(posedge clk_in)
  begin
    if (do_push)
    begin
      mem_r[wr_ptr_r] <= data_in;
    end
  end

  // pointers cleared by reset whatever is pending
  always_ff @(posedge clk_in)
  begin
    if (clear_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : cfa_stack

`default_nettype wire

//--- rtl/cfa_host.sv
`include "cfa_defines.svh"
`default_nettype none

module cfa_host #(
  parameter int WORD_W = `CFA_WORD_W
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // link to the device
  cfa_if.ext                     link,
  // device initialisation
  input  wire logic              clear_req_in,
  // word entry
  input  wire logic              wr_valid_in,
  input  wire logic [WORD_W-1:0] wr_data_in,
  output logic                   wr_ready_out,
  // word extraction
  input  wire logic              rd_req_in,
  output logic                   rd_valid_out,
  output logic [WORD_W-1:0]      rd_data_out,
  // row status
  input  wire logic [2:0]        row_irf_n_in,
  output logic                   row_in_ready_out,
  output logic                   slave_ies_n_out
);
  logic                 mr_n_r;
  logic                 pl_r;
  logic                 wait_low_r;
  logic [WORD_W-1:0]    pd_r;
  logic                 top_n_r;
  logic                 take;
  cfa_pkg::cfa_xtr_e    state_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mr_n_r <= 1'b0;
    end
    else
    begin
      mr_n_r <= !clear_req_in;
    end
  end

  assign link.master_reset_n           = mr_n_r;
  assign link.serial_input_enable_n    = 1'b0;
  assign link.serial_in_clock          = 1'b0;
  assign link.serial_data_in           = 1'b0;
  assign link.serial_output_enable_n   = 1'b0;
  assign link.serial_out_clock         = 1'b0;
  assign link.serial_extract_request_n = 1'b0;
  assign link.output_drive_enable_n    = 1'b0;
  assign link.transfer_to_stack_n      = link.input_register_full_n;
  assign link.parallel_load            = pl_r;
  assign link.par_data_in              = pd_r;
  assign link.parallel_extract_n       = top_n_r;

  // load only into an empty input register, once per word
  assign take = wr_valid_in && link.input_register_full_n && !pl_r
                && !wait_low_r && mr_n_r;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !mr_n_r)
    begin
      pl_r         <= 1'b0;
      wait_low_r   <= 1'b0;
      pd_r         <= '0;
      wr_ready_out <= 1'b0;
    end
    else
    begin
      pl_r         <= take;
      wr_ready_out <= take;
      if (take)
      begin
        pd_r       <= wr_data_in;
        wait_low_r <= 1'b1;
      end
      else if (!link.input_register_full_n)
      begin
        wait_low_r <= 1'b0;
      end
    end
  end

  // extraction pulse: low one cycle, then high
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !mr_n_r)
    begin
      state_r      <= cfa_pkg::CFA_XTR_IDLE;
      top_n_r      <= 1'b1;
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      case (state_r)
        cfa_pkg::CFA_XTR_IDLE:
        begin
          if (rd_req_in && link.output_register_empty_n)
          begin
            rd_data_out <= link.par_data_out;
            top_n_r     <= 1'b0;
            state_r     <= cfa_pkg::CFA_XTR_LOW;
          end
        end
        cfa_pkg::CFA_XTR_LOW:
        begin
          top_n_r      <= 1'b1;
          rd_valid_out <= 1'b1;
          state_r      <= cfa_pkg::CFA_XTR_WAIT;
        end
        cfa_pkg::CFA_XTR_WAIT:
        begin
          if (!link.output_register_empty_n)
          begin
            state_r <= cfa_pkg::CFA_XTR_IDLE;
          end
        end
        default:
        begin
          state_r <= cfa_pkg::CFA_XTR_IDLE;
        end
      endcase
    end
  end

  // row status and fast slave enabling
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      row_in_ready_out <= 1'b0;
      slave_ies_n_out  <= 1'b1;
    end
    else
    begin
      row_in_ready_out <= link.input_register_full_n && (&row_irf_n_in);
      slave_ies_n_out  <= link.input_register_full_n;
    end
  end
endmodule : cfa_host

`default_nettype wire

//--- tb/cfa_properties.sv
`default_nettype none

module cfa_properties (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // device inputs
  input wire logic       master_reset_n,
  input wire logic       transfer_to_stack_n,
  input wire logic       parallel_load,
  input wire logic       parallel_extract_n,
  // device outputs
  input wire logic       input_register_full_n,
  input wire logic       output_register_empty_n,
  input wire logic [3:0] par_data_out,
  input wire logic       par_data_oe,
  input wire logic       serial_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_in_reset;
    !master_reset_n [*2];
  endsequence

  sequence s_extract_low;
    $fell(parallel_extract_n);
  endsequence

  a_reset_full_high: assert property (s_in_reset |=> input_register_full_n)
    else $error("input full flag not high in master reset");
  a_reset_empty_low: assert property (s_in_reset |=> !output_register_empty_n)
    else $error("output ready flag not low in master reset");
  a_reset_drive_off: assert property (s_in_reset |=> !serial_data_oe && !par_data_oe)
    else $error("outputs still driven in master reset");
  a_load_sets_full: assert property (parallel_load && master_reset_n
    |-> ##2 !input_register_full_n)
    else $error("load did not set input full");
  a_push_before_clear: assert property ($rose(input_register_full_n) && master_reset_n
    && $past(master_reset_n) && $past(master_reset_n, 2)
    |-> !$past(transfer_to_stack_n, 2) || !$past(transfer_to_stack_n, 3))
    else $error("input cleared without stack transfer");
  a_fall_through: assert property ($fell(input_register_full_n) && !output_register_empty_n
    && parallel_extract_n |-> ##[1:8] output_register_empty_n)
    else $error("word did not reach empty output");
  a_extract_drops: assert property (s_extract_low |-> ##[1:2] !output_register_empty_n)
    else $error("output ready not low on extract");
  a_release_waits: assert property ($rose(parallel_extract_n)
    |-> !output_register_empty_n ##1 !output_register_empty_n)
    else $error("output ready high too soon after extract");
  a_oe_needs_word: assert property (!output_register_empty_n [*3] |-> !serial_data_oe)
    else $error("serial output driven without word");
  a_word_stands: assert property (output_register_empty_n && $past(output_register_empty_n)
    |-> $stable(par_data_out))
    else $error("output word changed while held");
endmodule : cfa_properties

`default_nettype wire

//--- tb/cascaded_fifo_array_status_tb.sv
`default_nettype none

module cascaded_fifo_array_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_in       = 1'b0;
  logic       rst_n_in     = 1'b0;
  logic       clear_req_in = 1'b0;
  logic       wr_valid_in  = 1'b0;
  logic [3:0] wr_data_in   = 4'h0;
  logic       rd_req_in    = 1'b0;
  logic [2:0] row_irf_n_in = 3'h7;
  logic       wr_ready_out;
  logic       rd_valid_out;
  logic [3:0] rd_data_out;
  logic       row_in_ready_out;
  logic       slave_ies_n_out;
  logic       is_master_out;
  logic       holds_output_out;
  int         failures     = 0;
  int         checks_done  = 0;
  int         cycles       = 0;
  integer     seed         = 32'h78E6080F;
  logic [3:0] model_q[$];
  bit         ok;
  logic       s_mr_n       = 1'b0;
  logic       s_ies_n      = 1'b1;
  logic       s_clk        = 1'b0;
  logic       s_din        = 1'b0;
  logic       s_oes_n      = 1'b0;
  logic       s_master;
  logic       s_holds;
  logic [3:0] sw;
  logic [3:0] scratch_w;

  always #5 clk_in = ~clk_in;

  cfa_if #(.WORD_W(4)) link ();

  cfa_dev cfa_dev_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
    .is_master_out(is_master_out), .holds_output_out(holds_output_out));

  cfa_host cfa_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
    .clear_req_in(clear_req_in), .wr_valid_in(wr_valid_in), .wr_data_in(wr_data_in),
    .wr_ready_out(wr_ready_out), .rd_req_in(rd_req_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .row_irf_n_in(row_irf_n_in),
    .row_in_ready_out(row_in_ready_out), .slave_ies_n_out(slave_ies_n_out));

  cfa_properties cfa_properties_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .master_reset_n(link.master_reset_n), .transfer_to_stack_n(link.transfer_to_stack_n),
    .parallel_load(link.parallel_load), .parallel_extract_n(link.parallel_extract_n),
    .input_register_full_n(link.input_register_full_n),
    .output_register_empty_n(link.output_register_empty_n),
    .par_data_out(link.par_data_out), .par_data_oe(link.par_data_oe),
    .serial_data_oe(link.serial_data_oe));

  // second device driven directly: serial entry as a row slave
  cfa_if #(.WORD_W(4)) slink ();

  assign slink.master_reset_n           = s_mr_n;
  assign slink.serial_input_enable_n    = s_ies_n;
  assign slink.serial_in_clock          = s_clk;
  assign slink.serial_data_in           = s_din;
  assign slink.transfer_to_stack_n      = slink.input_register_full_n;
  assign slink.parallel_load            = 1'b0;
  assign slink.par_data_in              = 4'h0;
  assign slink.serial_output_enable_n   = s_oes_n;
  assign slink.serial_out_clock         = 1'b0;
  assign slink.serial_extract_request_n = 1'b0;
  assign slink.parallel_extract_n       = 1'b1;
  assign slink.output_drive_enable_n    = 1'b0;

  if (1'b1)
  begin : g_serial
    cfa_dev cfa_dev_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(slink),
      .is_master_out(s_master), .holds_output_out(s_holds));
  end

  function automatic logic [3:0] row_ready(input logic [2:0] row);
    return 4'(&row);
  endfunction : row_ready

  task automatic print_verdict();
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic put_word(input logic [3:0] w, input int limit, output bit taken);
    int n;
    n = 0;
    taken = 1'b0;
    wr_data_in  <= w;
    wr_valid_in <= 1'b1;
    while (!taken && n < limit)
    begin
      @(posedge clk_in);
      n++;
      taken = (wr_ready_out === 1'b1);
    end
    wr_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask : put_word

  task automatic get_word(output logic [3:0] w, output bit got);
    int n;
    n = 0;
    got = 1'b0;
    w = 4'h0;
    rd_req_in <= 1'b1;
    while (!got && n < 60)
    begin
      @(posedge clk_in);
      n++;
      got = (rd_valid_out === 1'b1);
      w = rd_data_out;
    end
    rd_req_in <= 1'b0;
    @(posedge clk_in);
  endtask : get_word

  task automatic serial_bit(input logic b);
    s_din <= b;
    s_clk <= 1'b1;
    @(posedge clk_in);
    s_clk <= 1'b0;
    @(posedge clk_in);
  endtask : serial_bit

  task automatic put_model(input logic [3:0] w);
    bit taken;
    put_word(w, 60, taken);
    check("write taken", 4'h1, 4'(taken));
    if (taken)
      model_q.push_back(w);
  endtask : put_model

  task automatic pop_check();
    logic [3:0] w;
    bit         got;
    get_word(w, got);
    check("read taken", 4'h1, 4'(got));
    if (got && model_q.size() > 0)
      check("read word", model_q.pop_front(), w);
  endtask : pop_check

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("irf_n after reset", 4'h1, 4'(link.input_register_full_n));
    check("ore_n after reset", 4'h0, 4'(link.output_register_empty_n));
    check("serial oe after reset", 4'h0, 4'(link.serial_data_oe));
    check("master strap", 4'h1, 4'(is_master_out));
    check("holds after reset", 4'h0, 4'(holds_output_out));
    // random mix of writes and reads
    for (int i = 0; i < 40; i++)
    begin
      if ((($random(seed) & 1) != 0) && model_q.size() < 16)
        put_model(4'($random(seed)));
      else if (model_q.size() > 0)
        pop_check();
    end
    // fill to capacity, extra word refused until one leaves
    while (model_q.size() < 16)
      put_model(4'($random(seed)));
    put_word(4'hA, 40, ok);
    check("write refused when full", 4'h0, 4'(ok));
    check("irf_n held when full", 4'h0, 4'(link.input_register_full_n));
    check("row ready when full", 4'h0, 4'(row_in_ready_out));
    check("holds when full", 4'h1, 4'(holds_output_out));
    pop_check();
    put_model(4'hA);
    while (model_q.size() > 0)
      pop_check();
    // master reset drops stored words
    for (int i = 0; i < 3; i++)
      put_model(4'(i + 5));
    repeat (10) @(posedge clk_in);
    clear_req_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    clear_req_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    model_q.delete();
    check("irf_n after clear", 4'h1, 4'(link.input_register_full_n));
    check("ore_n after clear", 4'h0, 4'(link.output_register_empty_n));
    get_word(scratch_w, ok);
    check("read after clear", 4'h0, 4'(ok));
    put_model(4'hF);
    pop_check();
    // serial entry on the slave device
    s_mr_n <= 1'b1;
    repeat (2) @(posedge clk_in);
    check("slave strap", 4'h0, 4'(s_master));
    for (int b = 0; b < 4; b++)
      serial_bit(1'b1);
    repeat (2) @(posedge clk_in);
    check("disabled shift ignored", 4'h1, 4'(slink.input_register_full_n));
    sw = 4'($random(seed));
    s_ies_n <= 1'b0;
    for (int b = 0; b < 4; b++)
      serial_bit(sw[b]);
    serial_bit(~sw[0]);
    repeat (3) @(posedge clk_in);
    check("full after four bits", 4'h0, 4'(slink.input_register_full_n));
    check("slave ready held", 4'h0, 4'(slink.output_register_empty_n));
    check("serial word", sw, slink.par_data_out);
    check("serial bit out", 4'(sw[0]), 4'(slink.serial_data_out));
    check("serial oe with word", 4'h1, 4'(slink.serial_data_oe));
    check("slave holds word", 4'h1, 4'(s_holds));
    s_ies_n <= 1'b1;
    s_oes_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("slave input cleared", 4'h1, 4'(slink.input_register_full_n));
    check("slave ready released", 4'h1, 4'(slink.output_register_empty_n));
    // every row status code
    for (int i = 0; i < 8; i++)
    begin
      row_irf_n_in <= 3'(i);
      repeat (3) @(posedge clk_in);
      check("row ready", row_ready(3'(i)), 4'(row_in_ready_out));
      check("slave enable idle", 4'h1, 4'(slave_ies_n_out));
    end
    print_verdict();
  end
endmodule : cascaded_fifo_array_status_tb

`default_nettype wire
